// File: design/mdma_engine.sv
// Purpose: Sixteen-channel DMA engine with AHB manager and register port
// Assumes: Single clock, synchronous active-low reset, non-pipelined AHB
// Notes: Each grant moves one burst through the buffer, then re-arbitrates
`timescale 1ns/1ns
`default_nettype none
module mdma_engine
  import mdma_pkg::*;
#(
  parameter logic [31:0] PERIPH_FIFO_BASE = 32'h4000_0000
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Peripheral request lines, indexed by route code low bits
  input wire logic [31:0] periph_req,
  // AHB-Lite manager
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp
);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_RISSUE = 8'h02, ST_RADDR = 8'h04,
    ST_RDATA = 8'h08, ST_WISSUE = 8'h10, ST_WADDR = 8'h20,
    ST_WDATA = 8'h40, ST_FINISH = 8'h80
  } mdma_state_t;

  // Route code to transfer kind; reserved codes fall out as RK_RSV
  function automatic mdma_kind_t route_kind(input logic [5:0] code);
    logic rsv;
    rsv = (code[4:0] >= ROUTE_RSV_A && code[4:0] <= ROUTE_RSV_B) ||
          code[4:0] == ROUTE_RSV_C || code == ROUTE_RSV_GAP ||
          code == ROUTE_RSV_HI;
    if (code == ROUTE_MEM)
      route_kind = RK_MEM;
    else if (rsv)
      route_kind = RK_RSV;
    else if (code[5])
      route_kind = RK_M2P;
    else
      route_kind = RK_P2M;
  endfunction

  // Step within the low 24 bits; the top byte never changes
  function automatic logic [31:0] step_addr(input logic [31:0] a,
                                            input logic word);
    step_addr = {a[31:STEP_WIDTH],
                 a[STEP_WIDTH-1:0] + (word ? 24'h000004 : 24'h000001)};
  endfunction

  // Channel registers
  logic en_r [CH_COUNT];
  logic active_r [CH_COUNT];
  logic rld_r [CH_COUNT];
  logic [1:0] rank_r [CH_COUNT];
  logic [5:0] route_r [CH_COUNT];
  logic sstep_r [CH_COUNT];
  logic dstep_r [CH_COUNT];
  logic [4:0] burst_r [CH_COUNT];
  logic [31:0] src_r [CH_COUNT];
  logic [31:0] dst_r [CH_COUNT];
  logic [CNT_WIDTH-1:0] cnt_r [CH_COUNT];
  logic [31:0] srcrld_r [CH_COUNT];
  logic [31:0] dstrld_r [CH_COUNT];
  logic [CNT_WIDTH-1:0] cntrld_r [CH_COUNT];
  logic gate_r;

  // Engine state
  mdma_state_t state_r;
  logic [3:0] cur_r;
  logic [3:0] rr_r;
  logic [5:0] budget_r;
  logic [3:0] beats_r;
  logic [3:0] wbeat_r;
  logic [FIFO_WIDTH-1:0] fifo_r [FIFO_DEPTH];
  logic wide_r [FIFO_DEPTH];
  logic [31:0] haddr_r;
  logic [1:0] htrans_r;
  logic hwrite_r;
  logic [2:0] hsize_r;
  logic [2:0] hburst_r;
  logic [31:0] hwdata_r;
  logic [31:0] rdata_r;
  logic [31:0] preq_s1_r;
  logic [31:0] preq_s2_r;

  // Decode and arbitration signals
  logic [CH_COUNT-1:0] req;
  logic req_any;
  logic [1:0] top_rank;
  logic [3:0] gnt;
  logic found;
  logic [3:0] idx;
  logic ch_sel;
  logic [3:0] wch;
  logic [4:0] off;
  mdma_kind_t cur_kind;
  logic [31:0] periph_addr;
  logic beat_word;
  logic ev_rd;
  logic ev_wr;
  logic ev_end;
  logic ev_err;
  logic bus_busy;
  logic [3:0] bus_ch;

  assign ch_sel = ~reg_addr[9] & ~gate_r;
  assign wch = reg_addr[8:5];
  assign off = reg_addr[4:0];

  // Outputs straight from flops
  assign reg_rdata = rdata_r;
  assign haddr = haddr_r;
  assign htrans = htrans_r;
  assign hwrite = hwrite_r;
  assign hsize = hsize_r;
  assign hburst = hburst_r;
  assign hwdata = hwdata_r;

  // Peripheral requests cross in from other clocks
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      preq_s1_r <= 32'h0000_0000;
      preq_s2_r <= 32'h0000_0000;
    end
    else
    begin
      preq_s1_r <= periph_req;
      preq_s2_r <= preq_s1_r;
    end
  end

  // Per-channel request: enabled, active, legal route, peripheral ready unless memory route
  genvar gi;
  generate
    for (gi = 0; gi < CH_COUNT; gi++)
    begin : g_req
      mdma_kind_t k;
      assign k = route_kind(route_r[gi]);
      assign req[gi] = en_r[gi] & active_r[gi] & (k != RK_RSV) &
                       ((k == RK_MEM) | preq_s2_r[route_r[gi][4:0]]);
    end
  endgenerate

  // Priority first, then rotate from the last winner
  always_comb
  begin
    req_any = 1'b0;
    top_rank = 2'h0;
    gnt = 4'h0;
    found = 1'b0;
    idx = 4'h0;
    for (int i = 0; i < CH_COUNT; i++)
    begin
      if (req[i] && rank_r[i] >= top_rank)
        top_rank = rank_r[i];
      req_any = req_any | req[i];
    end
    for (int k = 1; k <= CH_COUNT; k++)
    begin
      idx = rr_r + 4'(k);
      if (!found && req[idx] && rank_r[idx] == top_rank)
      begin
        gnt = idx;
        found = 1'b1;
      end
    end
  end

  // Current channel's view of the bus side
  assign cur_kind = route_kind(route_r[cur_r]);
  assign periph_addr = PERIPH_FIFO_BASE | {19'h0, route_r[cur_r][4:0], 8'h00};
  assign beat_word = (cnt_r[cur_r] >= 24'h000004) && (budget_r >= 6'h04);

  // Events the engine hands to the channel registers
  assign ev_rd = (state_r == ST_RISSUE);
  assign ev_wr = (state_r == ST_WISSUE);
  assign ev_end = (state_r == ST_FINISH);
  assign ev_err = ((state_r == ST_RDATA) || (state_r == ST_WDATA)) & hresp;

  // Channel on the bus or granted at this edge; its disable waits
  assign bus_busy = (state_r != ST_IDLE) || (req_any && !gate_r);
  assign bus_ch = (state_r == ST_IDLE) ? gnt : cur_r;

  // Burst engine: one grant, read burst, write burst, release
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      cur_r <= 4'h0;
      rr_r <= 4'hF;
      budget_r <= 6'h00;
      beats_r <= 4'h0;
      wbeat_r <= 4'h0;
      haddr_r <= 32'h0000_0000;
      htrans_r <= HTRANS_IDLE;
      hwrite_r <= 1'b0;
      hsize_r <= HSIZE_BYTE;
      hburst_r <= HBURST_SINGLE;
      hwdata_r <= 32'h0000_0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (req_any && !gate_r)
          begin
            cur_r <= gnt;
            rr_r <= gnt;
            budget_r <= {1'b0, burst_r[gnt]} + 6'h01;
            beats_r <= 4'h0;
            wbeat_r <= 4'h0;
            if (cnt_r[gnt] == 24'h000000)
              state_r <= ST_FINISH;
            else
              state_r <= ST_RISSUE;
          end
        ST_RISSUE:
        begin
          haddr_r <= (cur_kind == RK_P2M) ? periph_addr : src_r[cur_r];
          htrans_r <= HTRANS_NONSEQ;
          hwrite_r <= 1'b0;
          hsize_r <= beat_word ? HSIZE_WORD : HSIZE_BYTE;
          wide_r[beats_r[2:0]] <= beat_word;
          budget_r <= budget_r - (beat_word ? 6'h04 : 6'h01);
          state_r <= ST_RADDR;
        end
        ST_RADDR:
          if (hready)
          begin
            htrans_r <= HTRANS_IDLE;
            state_r <= ST_RDATA;
          end
        ST_RDATA:
          if (hresp)
            state_r <= ST_IDLE;
          else if (hready)
          begin
            fifo_r[beats_r[2:0]] <= hsize_r == HSIZE_WORD ? hrdata :
                                    hrdata >> {haddr_r[1:0], 3'h0};
            beats_r <= beats_r + 4'h1;
            // Stop at count zero, burst size, or a full buffer
            if (cnt_r[cur_r] == 24'h000000 || budget_r == 6'h00 ||
                beats_r == 4'(FIFO_DEPTH - 1))
              state_r <= ST_WISSUE;
            else
              state_r <= ST_RISSUE;
          end
        ST_WISSUE:
        begin
          haddr_r <= (cur_kind == RK_M2P) ? periph_addr : dst_r[cur_r];
          htrans_r <= HTRANS_NONSEQ;
          hwrite_r <= 1'b1;
          hsize_r <= wide_r[wbeat_r[2:0]] ? HSIZE_WORD : HSIZE_BYTE;
          state_r <= ST_WADDR;
        end
        ST_WADDR:
          if (hready)
          begin
            htrans_r <= HTRANS_IDLE;
            // Byte beats replicate onto every lane
            hwdata_r <= wide_r[wbeat_r[2:0]] ? fifo_r[wbeat_r[2:0]] :
                        {4{fifo_r[wbeat_r[2:0]][7:0]}};
            state_r <= ST_WDATA;
          end
        ST_WDATA:
          if (hresp)
            state_r <= ST_IDLE;
          else if (hready)
          begin
            wbeat_r <= wbeat_r + 4'h1;
            if (wbeat_r + 4'h1 == beats_r)
              state_r <= ST_FINISH;
            else
              state_r <= ST_WISSUE;
          end
        ST_FINISH:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Clock gate bit; while it is set channel registers are closed to the port and no new grant is made
  always_ff @(posedge clock)
  begin
    if (!resetn)
      gate_r <= GATE_RESET;
    else if (reg_wr && reg_addr == GATE_ADDR)
      gate_r <= reg_wdata[0];
  end

  // Channel registers: software writes first, engine events override
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < CH_COUNT; c++)
      begin
        en_r[c] <= 1'b0;
        active_r[c] <= 1'b0;
        rld_r[c] <= 1'b0;
        rank_r[c] <= 2'h0;
        route_r[c] <= ROUTE_MEM;
        sstep_r[c] <= 1'b0;
        dstep_r[c] <= 1'b0;
        burst_r[c] <= BURST_RESET;
        src_r[c] <= 32'h0000_0000;
        dst_r[c] <= 32'h0000_0000;
        cnt_r[c] <= 24'h000000;
        srcrld_r[c] <= 32'h0000_0000;
        dstrld_r[c] <= 32'h0000_0000;
        cntrld_r[c] <= 24'h000000;
      end
    end
    else
    begin
      for (int c = 0; c < CH_COUNT; c++)
      begin
        if (reg_wr && ch_sel && wch == 4'(c))
          case (off)
            REG_CTRL:
            begin
              en_r[c] <= reg_wdata[CTL_EN_BIT];
              rld_r[c] <= reg_wdata[CTL_RLD_BIT];
              rank_r[c] <= reg_wdata[CTL_RANK_LSB +: 2];
              route_r[c] <= reg_wdata[CTL_ROUTE_LSB +: 6];
              sstep_r[c] <= reg_wdata[CTL_SSTEP_BIT];
              dstep_r[c] <= reg_wdata[CTL_DSTEP_BIT];
              burst_r[c] <= reg_wdata[CTL_BURST_LSB +: 5];
              if (reg_wdata[CTL_EN_BIT])
                active_r[c] <= 1'b1;
              else if (!bus_busy || bus_ch != 4'(c))
                active_r[c] <= 1'b0;
            end
            REG_SRC: src_r[c] <= reg_wdata;
            REG_DST: dst_r[c] <= reg_wdata;
            REG_CNT: cnt_r[c] <= reg_wdata[CNT_WIDTH-1:0];
            REG_SRCRLD: srcrld_r[c] <= reg_wdata;
            REG_DSTRLD: dstrld_r[c] <= reg_wdata;
            REG_CNTRLD: cntrld_r[c] <= reg_wdata[CNT_WIDTH-1:0];
            default: ;
          endcase
        if (cur_r == 4'(c))
        begin
          // Read beat: count down, step memory-side source only
          if (ev_rd)
          begin
            cnt_r[c] <= cnt_r[c] - (beat_word ? 24'h000004 : 24'h000001);
            if (sstep_r[c] && cur_kind != RK_P2M)
              src_r[c] <= step_addr(src_r[c], beat_word);
          end
          if (ev_wr && dstep_r[c] && cur_kind != RK_M2P)
            dst_r[c] <= step_addr(dst_r[c], wide_r[wbeat_r[2:0]]);
          // Burst end: count zero and a disable left pending while on the bus are judged here
          if (ev_end)
          begin
            if (cnt_r[c] == 24'h000000 && rld_r[c])
            begin
              src_r[c] <= srcrld_r[c];
              dst_r[c] <= dstrld_r[c];
              cnt_r[c] <= cntrld_r[c];
            end
            if (!en_r[c] || (cnt_r[c] == 24'h000000 && !rld_r[c]))
            begin
              active_r[c] <= 1'b0;
              en_r[c] <= 1'b0;
            end
          end
          if (ev_err)
          begin
            active_r[c] <= 1'b0;
            en_r[c] <= 1'b0;
          end
        end
      end
      // A software disable of an idle channel drops its active flag
      for (int c = 0; c < CH_COUNT; c++)
        if (!en_r[c] && active_r[c] &&
            (!bus_busy || bus_ch != 4'(c)) &&
            !(reg_wr && ch_sel && wch == 4'(c) && off == REG_CTRL))
          active_r[c] <= 1'b0;
    end
  end

  // Register read data, valid only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (!resetn)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd && reg_addr == GATE_ADDR)
      rdata_r <= {31'h0, gate_r};
    else if (reg_rd && ch_sel)
      case (off)
        REG_CTRL:
          rdata_r <= {15'h0, burst_r[wch], dstep_r[wch], sstep_r[wch],
                      route_r[wch], rank_r[wch], rld_r[wch], en_r[wch]};
        REG_STATE: rdata_r <= {31'h0, active_r[wch]};
        REG_SRC: rdata_r <= src_r[wch];
        REG_DST: rdata_r <= dst_r[wch];
        REG_CNT: rdata_r <= {8'h00, cnt_r[wch]};
        REG_SRCRLD: rdata_r <= srcrld_r[wch];
        REG_DSTRLD: rdata_r <= dstrld_r[wch];
        REG_CNTRLD: rdata_r <= {8'h00, cntrld_r[wch]};
        default: rdata_r <= 32'h0000_0000;
      endcase
    else
      rdata_r <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

// File: design/mdma_pkg.sv
// Purpose: Shared constants for the sixteen-channel DMA engine
// Assumes: 32-bit register port, AHB-Lite manager, single clock
// Notes: Per-channel register windows are 32 bytes apart
package mdma_pkg;
  // Channel count and buffer shape
  localparam int CH_COUNT = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 32;
  localparam int CNT_WIDTH = 24;
  localparam int STEP_WIDTH = 24;
  // Register window decode
  localparam logic [9:0] GATE_ADDR = 10'h200;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATE = 5'h04;
  localparam logic [4:0] REG_SRC = 5'h08;
  localparam logic [4:0] REG_DST = 5'h0C;
  localparam logic [4:0] REG_CNT = 5'h10;
  localparam logic [4:0] REG_SRCRLD = 5'h14;
  localparam logic [4:0] REG_DSTRLD = 5'h18;
  localparam logic [4:0] REG_CNTRLD = 5'h1C;
  // Control word fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_RLD_BIT = 1;
  localparam int CTL_RANK_LSB = 2;
  localparam int CTL_ROUTE_LSB = 4;
  localparam int CTL_SSTEP_BIT = 10;
  localparam int CTL_DSTEP_BIT = 11;
  localparam int CTL_BURST_LSB = 12;
  localparam int STATE_ACTIVE_BIT = 0;
  // Reset values
  localparam logic GATE_RESET = 1'b1;
  localparam logic [4:0] BURST_RESET = 5'h1F;
  // Route select codes
  localparam logic [5:0] ROUTE_MEM = 6'h00;
  localparam logic [5:0] ROUTE_RSV_GAP = 6'h20;
  localparam logic [5:0] ROUTE_RSV_HI = 6'h29;
  localparam logic [4:0] ROUTE_RSV_A = 5'h0B;
  localparam logic [4:0] ROUTE_RSV_B = 5'h0D;
  localparam logic [4:0] ROUTE_RSV_C = 5'h1D;
  // Route kinds
  typedef enum logic [1:0] {
    RK_MEM = 2'h0, RK_P2M = 2'h1, RK_M2P = 2'h2, RK_RSV = 2'h3
  } mdma_kind_t;
  // AHB encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
endpackage

// File: verification/mdma_engine_chk.sv
// Purpose: Bus and register port checks for the DMA engine
// Assumes: Only the top-level ports are visible
// Notes: Helper logic tracks AHB phases and buffered beats
`timescale 1ns/1ns
`default_nettype none
module mdma_engine_chk
  import mdma_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // AHB manager
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hresp
);
  logic gate_r, dph_r, dwr_r, wmode_r;
  logic err, rd_acc, wr_acc, wr_wait, rd_issue;
  logic [3:0] beats_r;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // Data phase outcomes
  assign err = dph_r && hresp;
  assign rd_acc = dph_r && hready && !hresp && !dwr_r;
  assign wr_acc = dph_r && hready && !hresp && dwr_r;
  assign wr_wait = dph_r && dwr_r && !hready && !hresp;
  assign rd_issue = htrans == HTRANS_NONSEQ && !hwrite;

  // Phase tracking for non-pipelined singles
  always_ff @(posedge clock)
    if (!resetn)
    begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
    end
    else if (dph_r)
      dph_r <= !(hready || hresp);
    else
    begin
      dph_r <= htrans == HTRANS_NONSEQ && hready;
      dwr_r <= hwrite;
    end

  // Beats held in the buffer; an error drops them
  always_ff @(posedge clock)
    if (!resetn || err)
    begin
      beats_r <= 4'h0;
      wmode_r <= 1'b0;
    end
    else if (rd_acc)
      beats_r <= beats_r + 4'h1;
    else if (wr_acc)
    begin
      beats_r <= beats_r - 4'h1;
      wmode_r <= beats_r != 4'h1;
    end

  // Mirror of the clock gate bit
  always_ff @(posedge clock)
    if (!resetn)
      gate_r <= GATE_RESET;
    else if (reg_wr && reg_addr == GATE_ADDR)
      gate_r <= reg_wdata[0];

  sequence addr_wait_s;
    htrans == HTRANS_NONSEQ && !hready;
  endsequence
  sequence addr_held_s;
    htrans == HTRANS_NONSEQ && $stable(haddr) && $stable(hwrite)
      && $stable(hsize);
  endsequence

  gate_idle_a: assert property (gate_r |-> htrans == HTRANS_IDLE)
    else $error("bus cycle while clock gated");
  read_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  addr_hold_a: assert property (addr_wait_s |=> addr_held_s)
    else $error("address phase changed before ready");
  data_hold_a: assert property (wr_wait |=> $stable(hwdata))
    else $error("write data changed before ready");
  err_stop_a: assert property (err |=> htrans == HTRANS_IDLE [*2])
    else $error("transfer went on after bus error");
  write_order_a: assert property (wr_acc |-> beats_r != 4'h0)
    else $error("write beat with empty buffer");
  read_order_a: assert property (rd_issue |-> !wmode_r)
    else $error("read beat before buffer drained");
  buffer_depth_a: assert property (beats_r <= FIFO_DEPTH)
    else $error("buffer holds too many beats");
endmodule
`default_nettype wire

// File: verification/mdma_mem_model.sv
// Purpose: Behavioural AHB memory and peripheral FIFO space
// Assumes: Non-pipelined single beats, byte lanes by address
// Notes: Stalls and error replies are commanded by the bench
`timescale 1ns/1ns
`default_nettype none
module mdma_mem_model
  import mdma_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Manager side
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp,
  // Scenario controls
  input wire logic slow,
  input wire logic err_en,
  input wire logic [31:0] err_addr
);
  logic [31:0] mem [0:4095];
  logic [31:0] rnd_r, da_r;
  logic dph_r, dwr_r, dbyte_r;

  // Known contents; the bench expects the same pattern
  initial
    for (int i = 0; i < 4096; i++)
      mem[i] = {~i[15:0], i[15:0]};

  // Error only on the commanded address, never stalled
  assign hresp = dph_r && err_en && da_r == err_addr;
  assign hready = !slow || rnd_r[0] || hresp;
  // Released read bus shows a changing pattern, not old data
  assign hrdata = dph_r && !dwr_r ? mem[da_r[13:2]] : rnd_r;

  // One beat at a time, like the real slave
  always @(posedge clock)
  begin
    rnd_r <= resetn ? {rnd_r[30:0], rnd_r[31] ^ rnd_r[21] ^ rnd_r[1]
      ^ rnd_r[0]} : 32'h5A5A0F0F;
    if (!resetn)
      dph_r <= 1'b0;
    else if (dph_r && hready)
    begin
      dph_r <= 1'b0;
      if (dwr_r && !hresp && dbyte_r)
        mem[da_r[13:2]][{da_r[1:0], 3'b000} +: 8] <= hwdata[7:0];
      else if (dwr_r && !hresp)
        mem[da_r[13:2]] <= hwdata;
    end
    else if (htrans == HTRANS_NONSEQ && hready)
    begin
      dph_r <= 1'b1;
      dwr_r <= hwrite;
      dbyte_r <= hsize == HSIZE_BYTE;
      da_r <= haddr;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_multichannel_dma_engine.sv
// Purpose: Self-checking bench for the sixteen-channel DMA engine
// Assumes: Memory model on AHB, bench drives peripheral requests
// Notes: Channels, counts, ranks and stalls from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module tb_multichannel_dma_engine
  import mdma_pkg::*;
;
  logic clock, resetn, reg_wr, reg_rd, hwrite, hready, hresp, slow, err_en;
  logic [9:0] reg_addr;
  logic [1:0] htrans;
  logic [2:0] hsize, hburst;
  logic [31:0] reg_wdata, reg_rdata, periph_req, haddr, hwdata, hrdata;
  logic [31:0] err_addr, lfsr_r;
  int n_errors = 0, tests_run = 0, cycles = 0;

  mdma_engine i_mdma_engine (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hburst(hburst), .hwdata(hwdata), .hrdata(hrdata), .hready(hready),
    .hresp(hresp));
  mdma_mem_model i_mdma_mem_model (.clock(clock), .resetn(resetn),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp),
    .slow(slow), .err_en(err_en), .err_addr(err_addr));

  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r;
  endfunction
  function automatic logic [31:0] pat(input int i);
    return {~i[15:0], i[15:0]};
  endfunction
  function automatic logic [9:0] ca(input logic [3:0] ch, logic [4:0] off);
    return {1'b0, ch, off};
  endfunction
  // Full burst size, both address steps on
  function automatic logic [31:0] ctrl(input logic en, rl,
      input logic [1:0] rank, input logic [5:0] route);
    return {15'h0, 5'h1F, 2'b11, route, rank, rl, en};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobe gap of one cycle keeps drivers single per time step
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic setup(input logic [3:0] ch, input logic [31:0] s, t, n, c);
    wr(ca(ch, REG_SRC), s);
    wr(ca(ch, REG_DST), t);
    wr(ca(ch, REG_CNT), n);
    wr(ca(ch, REG_CTRL), c);
  endtask
  // Software side polls the flag before calling a channel stopped
  task automatic wait_idle(input logic [3:0] ch);
    logic [31:0] d;
    int k;
    d = 32'h1;
    k = 0;
    while (d !== 32'h0 && k < 3000)
    begin
      rd(ca(ch, REG_STATE), d);
      k++;
    end
    chk("active flag", 32'h0, d);
  endtask
  task automatic cmp(input int s, t, w);
    for (int k = 0; k < w; k++)
      chk("copied word", pat(s + k), i_mdma_mem_model.mem[t + k]);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Hang guard, well above the expected run length
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] d, r, n, t;
    logic [5:0] rsv [7];
    lfsr_r = 32'hFB68;
    {resetn, reg_wr, reg_rd, slow, err_en} = 5'h0;
    reg_addr = 10'h0;
    reg_wdata = 32'h0;
    periph_req = 32'h0;
    err_addr = 32'h0;
    rsv = '{6'h0B, 6'h0D, 6'h1D, ROUTE_RSV_GAP, ROUTE_RSV_HI, 6'h2B, 6'h3D};
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(GATE_ADDR, d);
    chk("clock gate", 32'h1, d);
    wr(ca(4'h0, REG_SRC), 32'h1234);
    wr(GATE_ADDR, 32'h0);
    rd(ca(4'h0, REG_SRC), d);
    chk("gated write", 32'h0, d);
    rd(ca(4'hF, REG_CTRL), d);
    chk("control reset", ctrl(1'b0, 1'b0, 2'h0, 6'h0) & 32'h1F000, d);
    rd(10'h204, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      slow <= i[0];
      r = rnd();
      n = 32'h4 * (32'h1 + r[7:4]) + 32'h2;
      t = 32'h2000 + 32'(i) * 32'h100;
      setup(r[11:8], 32'h1000, t, n, ctrl(1'b1, 1'b0, r[1:0], ROUTE_MEM));
      wait_idle(r[11:8]);
      rd(ca(r[11:8], REG_CTRL), d);
      chk("enable cleared", ctrl(1'b0, 1'b0, r[1:0], ROUTE_MEM), d);
      rd(ca(r[11:8], REG_CNT), d);
      chk("count", 32'h0, d);
      rd(ca(r[11:8], REG_SRC), d);
      chk("source step", 32'h1000 + n, d);
      rd(ca(r[11:8], REG_DST), d);
      chk("dest step", t + n, d);
      cmp(1024, t / 4, n / 4);
      r = (pat(t / 4 + n / 4) & 32'hFFFF0000) | (pat(1024 + n / 4) & 32'hFFFF);
      chk("tail bytes", r, i_mdma_mem_model.mem[t / 4 + n / 4]);
    end
    $display("test copy done");
    wr(ca(4'h5, REG_SRCRLD), 32'h1040);
    wr(ca(4'h5, REG_DSTRLD), 32'h3000);
    wr(ca(4'h5, REG_CNTRLD), 32'h8);
    setup(4'h5, 32'h1000, 32'h2800, 32'h10, ctrl(1'b1, 1'b1, 2'h0, 6'h0));
    repeat (150) @(posedge clock);
    wr(ca(4'h5, REG_CTRL), ctrl(1'b0, 1'b1, 2'h0, 6'h0));
    wait_idle(4'h5);
    cmp(1024, 2560, 4);
    cmp(1040, 3072, 2);
    $display("test reload done");
    setup(4'h6, 32'h0, 32'h3400, 32'h10, ctrl(1'b1, 1'b0, 2'h0, 6'h01));
    repeat (30) @(posedge clock);
    rd(ca(4'h6, REG_CNT), d);
    chk("count without request", 32'h10, d);
    periph_req[1] <= 1'b1;
    wait_idle(4'h6);
    for (int k = 0; k < 4; k++)
      chk("fifo source", pat(64), i_mdma_mem_model.mem[3328 + k]);
    setup(4'h7, 32'h1000, 32'h3800, 32'h10, ctrl(1'b1, 1'b0, 2'h0, 6'h21));
    wait_idle(4'h7);
    chk("fifo dest", pat(1027), i_mdma_mem_model.mem[64]);
    $display("test peripheral done");
    periph_req <= 32'hFFFFFFFF;
    for (int i = 0; i < 7; i++)
    begin
      setup(4'h8, 32'h1000, 32'h3C00, 32'h10, ctrl(1'b1, 1'b0, 2'h0, rsv[i]));
      repeat (20) @(posedge clock);
      rd(ca(4'h8, REG_CNT), d);
      chk("reserved count", 32'h10, d);
      wr(ca(4'h8, REG_CTRL), 32'h0);
      wait_idle(4'h8);
    end
    periph_req <= 32'h0;
    setup(4'h9, 32'h1000, 32'h3C00, 32'h0, ctrl(1'b1, 1'b0, 2'h0, 6'h0));
    wait_idle(4'h9);
    chk("no data moved", pat(3840), i_mdma_mem_model.mem[3840]);
    $display("test reserved done");
    err_addr <= 32'h1008;
    err_en <= 1'b1;
    setup(4'hA, 32'h1000, 32'h3E00, 32'h20, ctrl(1'b1, 1'b0, 2'h2, 6'h0));
    wait_idle(4'hA);
    chk("aborted write", pat(3968), i_mdma_mem_model.mem[3968]);
    rd(ca(4'hA, REG_CTRL), d);
    chk("enable after error", ctrl(1'b0, 1'b0, 2'h2, 6'h0), d);
    err_en <= 1'b0;
    $display("test error done");
    setup(4'h1, 32'h1000, 32'h2C00, 32'h40, ctrl(1'b0, 1'b0, 2'h0, 6'h0));
    setup(4'h2, 32'h1000, 32'h2E00, 32'h40, ctrl(1'b1, 1'b0, 2'h3, 6'h0));
    wr(ca(4'h1, REG_CTRL), ctrl(1'b1, 1'b0, 2'h0, 6'h0));
    // Look while the high rank's last burst still drains
    d = 32'h1;
    while (d !== 32'h0)
      rd(ca(4'h2, REG_CNT), d);
    rd(ca(4'h1, REG_CNT), d);
    chk("low rank count", 32'h40, d);
    wait_idle(4'h2);
    wait_idle(4'h1);
    cmp(1024, 2816, 16);
    setup(4'h4, 32'h1000, 32'h2C00, 32'h40, ctrl(1'b1, 1'b0, 2'h1, 6'h0));
    setup(4'h3, 32'h1000, 32'h2E00, 32'h40, ctrl(1'b1, 1'b0, 2'h1, 6'h0));
    wait_idle(4'h3);
    rd(ca(4'h4, REG_CNT), d);
    chk("rotated count", 32'h0, d);
    $display("test arbiter done");
    slow <= 1'b1;
    setup(4'hB, 32'h1000, 32'h2400, 32'h100, ctrl(1'b1, 1'b0, 2'h0, 6'h0));
    repeat (15) @(posedge clock);
    wr(ca(4'hB, REG_CTRL), ctrl(1'b0, 1'b0, 2'h0, 6'h0));
    wait_idle(4'hB);
    rd(ca(4'hB, REG_CNT), d);
    chk("whole bursts", 32'h0, {27'h0, d[4:0]});
    cmp(1024, 2304, (256 - int'(d[8:0])) / 4);
    chk("burst kind", 32'(HBURST_SINGLE), 32'(hburst));
    $display("test disable done");
    wrap_up();
  end
endmodule

bind mdma_engine mdma_engine_chk i_mdma_engine_chk (.clock(clock),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hresp(hresp));
`default_nettype wire
